// ==== wdrc_pkg.sv ====
// constants, field layout and helper function of the watchdog and reset-cause block
//
// Operation
// - debug-port reset flag, bit 4, set while debug reset active; cleared by power-on or zero-write.
// - watchdog reset flag, bit 3, set on watchdog reset; cleared by power-on or zero-write.
// - brown-out reset flag, bit 2, set on brown-out; cleared by power-on or zero-write.
// - external reset flag, bit 1, set on pin reset; cleared by power-on or zero-write.
// - power-on flag, bit 0, set by power-on; only a zero-write clears it.
// - watchdog count advances on a 1 MHz oscillator tick, independent of cpu clock; here the tick is divided down from clk_sys by 125.
// - count restarts on restart instruction, while disabled, and on any chip reset.
// - elapsed period without restart resets the chip.
// - fuse picks level 1 (starts disabled) or level 2 (forced on).
// - control bits 7..5 read zero and ignore writes.
// - change-enable clears itself four clock cycles after being set.
// - writing one enables; writing zero disables only while change-enable is set.
// - at level 2 the disable sequence leaves the watchdog enabled.
// - period select changes only inside the change-enable window.
// - period code 0 gives 16K oscillator cycles, doubling to 2048K at code 7.
// - time-out gives one internal reset pulse of exactly one clock cycle.
// - at level 1 enable may be set any time without a timed sequence.
// - at level 2 enable reads one and written enable value is ignored.
package wdrc_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_FREQ_HZ = 125_000_000;
    localparam int unsigned OSC_FREQ_HZ = 1_000_000;
    localparam int unsigned OSC_DIV = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam logic [6:0] OSC_DIV_LAST = 7'(OSC_DIV - 1);
    localparam int unsigned CNT_W = 22;
    localparam logic [CNT_W-1:0] TIMEOUT_BASE_TICKS_DEF = 22'h004000;
    localparam logic [2:0] CE_HOLD_CYCLES = 3'h4;

    // ************************************************************
    // register map and fields
    // ************************************************************
    localparam logic [3:0] ADDR_RESET_CAUSE = 4'h0;
    localparam logic [3:0] ADDR_CONTROL = 4'h4;
    localparam int unsigned POR_FLAG_BIT = 0;
    localparam int unsigned EXT_FLAG_BIT = 1;
    localparam int unsigned BOR_FLAG_BIT = 2;
    localparam int unsigned WD_FLAG_BIT = 3;
    localparam int unsigned DBG_FLAG_BIT = 4;
    localparam int unsigned CE_BIT = 4;
    localparam int unsigned EN_BIT = 3;
    localparam int unsigned PSEL_LSB = 0;
    localparam logic [4:0] CAUSE_RESET = 5'h01;
    localparam logic [2:0] PSEL_RESET = 3'h0;

    // last tick index of the selected period
    function automatic logic [CNT_W-1:0] periodLast(input logic [CNT_W-1:0] base,
                                                    input logic [2:0] psel);
        periodLast = (base << psel) - 22'h000001;
    endfunction
endpackage

// ==== wdrc_osc_tick.sv ====
// divider standing in for the watchdog's own oscillator, one tick per oscillator period
`timescale 1ns/1ps
module wdrc_osc_tick (
    input wire logic clk_sys,
    input wire logic rstN,
    output logic tick
);
    logic [6:0] divCnt_q;
    logic [6:0] divCnt_d;
    logic tick_d;
    logic tick_q;

    // free running: the oscillator never stops for software
    always_comb begin
        tick_d = (divCnt_q == wdrc_pkg::OSC_DIV_LAST);
        divCnt_d = tick_d ? 7'h00 : divCnt_q + 7'h01;
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            divCnt_q <= 7'h00;
            tick_q <= 1'b0;
        end else begin
            divCnt_q <= divCnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule // wdrc_osc_tick

// ==== wdrc_top.sv ====
// watchdog timer with timed-sequence control and reset-cause status register
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module wdrc_top #(
    parameter logic [wdrc_pkg::CNT_W-1:0] TIMEOUT_BASE_TICKS = wdrc_pkg::TIMEOUT_BASE_TICKS_DEF
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    input wire logic restartInstr,
    input wire logic extResetEvent,
    input wire logic brownoutEvent,
    input wire logic debugResetLevel,
    input wire logic alwaysOnFuse,
    output logic watchdogResetPulse,
    output logic watchdogActive
);
    localparam int unsigned CW = wdrc_pkg::CNT_W;

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rstSync_q;
    logic rstN;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstN = rstSync_q[1];

    // ************************************************************
    // fuse capture
    // ************************************************************
    logic fuseCaught_q;
    logic fuseCaught_d;
    logic level2_q;
    logic level2_d;

    // strap is caught once after release, later fuse changes have no effect
    always_comb begin
        fuseCaught_d = 1'b1;
        level2_d = fuseCaught_q ? level2_q : alwaysOnFuse;
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            fuseCaught_q <= 1'b0;
            level2_q <= 1'b0;
        end else begin
            fuseCaught_q <= fuseCaught_d;
            level2_q <= level2_d;
        end
    end

    // ************************************************************
    // avalon slave
    // ************************************************************
    logic ack_q;
    logic ack_d;
    logic [31:0] readdata_q;
    logic [31:0] readdata_d;
    logic causeWrite;
    logic ctrlWrite;
    logic [7:0] causeRead;
    logic [7:0] ctrlRead;
    logic [4:0] cause_q;
    logic ce_q;
    logic en_q;
    logic [2:0] psel_q;
    logic effEn;

    assign effEn = en_q | level2_q;
    assign causeRead = {3'h0, cause_q};
    assign ctrlRead = {3'h0, ce_q, effEn, psel_q};
    assign causeWrite = avsWrite & ack_q & avsByteenable[0] &
                        (avsAddress == wdrc_pkg::ADDR_RESET_CAUSE);
    assign ctrlWrite = avsWrite & ack_q & avsByteenable[0] &
                       (avsAddress == wdrc_pkg::ADDR_CONTROL);

    // one wait state per access, unmapped addresses read zero
    always_comb begin
        ack_d = (avsRead | avsWrite) & ~ack_q;
        readdata_d = readdata_q;
        if (avsRead & ~ack_q) begin
            case (avsAddress)
                wdrc_pkg::ADDR_RESET_CAUSE: readdata_d = {24'h000000, causeRead};
                wdrc_pkg::ADDR_CONTROL: readdata_d = {24'h000000, ctrlRead};
                default: readdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ack_q <= 1'b0;
            readdata_q <= 32'h00000000;
        end else begin
            ack_q <= ack_d;
            readdata_q <= readdata_d;
        end
    end

    assign avsWaitrequest = (avsRead | avsWrite) & ~ack_q;
    assign avsReaddata = readdata_q;

    // ************************************************************
    // watchdog control
    // ************************************************************
    logic ce_d;
    logic en_d;
    logic [2:0] psel_d;
    logic [2:0] ceCnt_q;
    logic [2:0] ceCnt_d;
    logic cfgApplied;
    logic wdPulse_q;
    logic anyChipRst;
    logic [7:0] wData;

    assign wData = avsWritedata[7:0];
    assign anyChipRst = extResetEvent | brownoutEvent | debugResetLevel | wdPulse_q;

    always_comb begin
        ce_d = ce_q;
        en_d = en_q;
        psel_d = psel_q;
        ceCnt_d = ceCnt_q;
        cfgApplied = 1'b0;
        if (ce_q) begin
            ceCnt_d = ceCnt_q - 3'h1;
            if (ceCnt_q == 3'h1) begin
                ce_d = 1'b0;
            end
        end
        if (ctrlWrite) begin
            if (ce_q) begin
                en_d = wData[wdrc_pkg::EN_BIT];
                psel_d = wData[wdrc_pkg::PSEL_LSB +: 3];
                ce_d = 1'b0;
                cfgApplied = 1'b1;
            end else begin
                en_d = en_q | wData[wdrc_pkg::EN_BIT];
            end
            if (wData[wdrc_pkg::CE_BIT] & wData[wdrc_pkg::EN_BIT]) begin
                ce_d = 1'b1;
                ceCnt_d = wdrc_pkg::CE_HOLD_CYCLES;
            end
        end
        // a chip reset returns the control register to its initial value
        if (anyChipRst) begin
            ce_d = 1'b0;
            en_d = 1'b0;
            psel_d = wdrc_pkg::PSEL_RESET;
            ceCnt_d = 3'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ce_q <= 1'b0;
            en_q <= 1'b0;
            psel_q <= wdrc_pkg::PSEL_RESET;
            ceCnt_q <= 3'h0;
        end else begin
            ce_q <= ce_d;
            en_q <= en_d;
            psel_q <= psel_d;
            ceCnt_q <= ceCnt_d;
        end
    end

    // ************************************************************
    // time-out counter
    // ************************************************************
    logic tick;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic restartNow;
    logic timeoutHit;

    wdrc_osc_tick u_osc (
        .clk_sys(clk_sys),
        .rstN(rstN),
        .tick(tick)
    );

    assign restartNow = restartInstr | ~effEn | anyChipRst | cfgApplied;
    // >= rather than == so a shrinking period can never be skipped past
    assign timeoutHit = effEn & tick & ~restartNow &
                        (cnt_q >= wdrc_pkg::periodLast(TIMEOUT_BASE_TICKS, psel_q));

    always_comb begin
        cnt_d = cnt_q;
        if (restartNow | timeoutHit) begin
            cnt_d = '0;
        end else if (tick) begin
            cnt_d = cnt_q + 22'h000001;
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            cnt_q <= '0;
            wdPulse_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            wdPulse_q <= timeoutHit;
        end
    end

    assign watchdogResetPulse = wdPulse_q;
    assign watchdogActive = effEn;

    // ************************************************************
    // reset cause flags
    // ************************************************************
    logic [4:0] cause_d;
    logic [4:0] causeSet;
    logic [4:0] causeClr;

    always_comb begin
        causeSet = 5'h00;
        causeSet[wdrc_pkg::DBG_FLAG_BIT] = debugResetLevel;
        causeSet[wdrc_pkg::WD_FLAG_BIT] = timeoutHit;
        causeSet[wdrc_pkg::BOR_FLAG_BIT] = brownoutEvent;
        causeSet[wdrc_pkg::EXT_FLAG_BIT] = extResetEvent;
        causeClr = causeWrite ? ~wData[4:0] : 5'h00;
        // a set in the same cycle as a clear wins
        cause_d = (cause_q & ~causeClr) | causeSet;
    end

    // power-on is the only reset of this register; it leaves just the power-on flag
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            cause_q <= wdrc_pkg::CAUSE_RESET;
        end else begin
            cause_q <= cause_d;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstN);

    pulse_one_cycle_a: assert property (wdPulse_q |=> !wdPulse_q)
        else $error("watchdog reset pulse longer than one cycle");
    timeout_pulse_a: assert property (timeoutHit |=> wdPulse_q ##1 (cnt_q == '0))
        else $error("time-out did not give a reset pulse");
    wd_flag_set_a: assert property ($rose(wdPulse_q) |-> cause_q[3])
        else $error("watchdog flag not set by time-out");
    ext_flag_set_a: assert property (extResetEvent |=> cause_q[1] && !en_q)
        else $error("external reset flag not set");
    bor_flag_set_a: assert property (brownoutEvent |=> cause_q[2])
        else $error("brown-out flag not set");
    dbg_flag_set_a: assert property (debugResetLevel |=> cause_q[4])
        else $error("debug reset flag not set");
    por_flag_kept_a: assert property (cause_q[0] && !causeWrite |=> cause_q[0])
        else $error("power-on flag lost without a write");
    flag_clear_a: assert property (causeWrite && !wData[1] && !extResetEvent |=> !cause_q[1])
        else $error("zero write did not clear flag");
    ce_self_clear_a: assert property ($rose(ce_q) && !ctrlWrite ##1 !ctrlWrite[*4]
                                      |-> !ce_q)
        else $error("change-enable not cleared after four cycles");
    ce_held_a: assert property (ce_q && ceCnt_q != 3'h1 && !ctrlWrite && !anyChipRst |=> ce_q)
        else $error("change-enable dropped early");
    level2_on_a: assert property (level2_q && ack_q && avsRead &&
                                  avsAddress == wdrc_pkg::ADDR_CONTROL
                                  |-> watchdogActive && avsReaddata[wdrc_pkg::EN_BIT])
        else $error("level 2 watchdog not enabled");
    no_disable_a: assert property (effEn && !ce_q && !anyChipRst |=> effEn)
        else $error("watchdog disabled outside the window");
    psel_guard_a: assert property (!ce_q && !anyChipRst |=> $stable(psel_q))
        else $error("period select changed outside the window");
    window_apply_a: assert property (ctrlWrite && ce_q && !anyChipRst
                                     |=> psel_q == $past(wData[2:0]) && cnt_q == '0)
        else $error("window write not applied");
    restart_a: assert property (restartInstr |=> cnt_q == '0)
        else $error("restart instruction did not clear count");
    count_on_tick_a: assert property (!tick && !restartNow |=> $stable(cnt_q))
        else $error("count advanced without oscillator tick");
    reserved_zero_a: assert property (ack_q && avsRead && avsAddress == 4'h4
                                      |-> avsReaddata[7:5] == 3'h0)
        else $error("reserved control bits not zero");
    level1_set_a: assert property (ctrlWrite && wData[3] && !anyChipRst |=> en_q)
        else $error("enable write ignored");
    fuse_start_a: assert property (fuseCaught_q && !level2_q && $past(anyChipRst)
                                   |-> !effEn)
        else $error("level 1 watchdog not disabled after reset");

    timeout_c: cover property (timeoutHit);
    disable_seq_c: cover property (effEn ##1 !effEn);
    psel_change_c: cover property (ctrlWrite && ce_q && wData[2:0] != psel_q);
    dbg_flag_c: cover property ($rose(cause_q[4]));
endmodule // wdrc_top

// ==== wdrc_top_tb_top.sv ====
// self-checking testbench of the watchdog and reset-cause block
`timescale 1ns/1ps
module wdrc_top_tb_top;
    localparam int DIV = 125;
    logic clkSys = 1'b0;
    logic arstN = 1'b0;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h00000000;
    logic [3:0] avsByteenable = 4'hF;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic [3:0] evt = 4'h0;
    logic alwaysOnFuse = 1'b0;
    logic watchdogResetPulse;
    logic watchdogActive;
    int nErrors = 0;
    int samplesChecked = 0;
    int flagPos [1:3] = '{wdrc_pkg::EXT_FLAG_BIT, wdrc_pkg::BOR_FLAG_BIT, wdrc_pkg::DBG_FLAG_BIT};

    always #4 clkSys = ~clkSys;

    // base of 4 ticks keeps the longest period at 512 ticks
    wdrc_top #(.TIMEOUT_BASE_TICKS(22'h000004)) u_dut (
        .clk_sys(clkSys),
        .arst_n(arstN),
        .avsAddress(avsAddress),
        .avsRead(avsRead),
        .avsWrite(avsWrite),
        .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable),
        .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest),
        .restartInstr(evt[0]),
        .extResetEvent(evt[1]),
        .brownoutEvent(evt[2]),
        .debugResetLevel(evt[3]),
        .alwaysOnFuse(alwaysOnFuse),
        .watchdogResetPulse(watchdogResetPulse),
        .watchdogActive(watchdogActive)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic stopTest();
        $display("comparisons %0d, mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask

    // waitrequest and read data are both taken at the rising edge that ends the access
    task automatic busWait(output logic [31:0] d);
        int n;
        n = 0;
        forever begin
            @(posedge clkSys);
            if (avsWaitrequest === 1'b0) break;
            n++;
            if (n > 20) begin
                nErrors++;
                stopTest();
            end
        end
        d = avsReaddata;
    endtask

    task automatic busWr(input logic [3:0] a, input logic [7:0] v, input logic [3:0] be = 4'hF);
        logic [31:0] d;
        @(posedge clkSys);
        avsAddress <= a;
        avsWritedata <= {24'h000000, v};
        avsByteenable <= be;
        avsWrite <= 1'b1;
        busWait(d);
        avsWrite <= 1'b0;
    endtask

    task automatic chkReg(input logic [3:0] a, input logic [7:0] exp);
        logic [31:0] d;
        @(posedge clkSys);
        avsAddress <= a;
        avsRead <= 1'b1;
        busWait(d);
        avsRead <= 1'b0;
        chkVal(d, {24'h000000, exp});
    endtask

    task automatic fire(input int i);
        @(posedge clkSys);
        evt[i] <= 1'b1;
        @(posedge clkSys);
        evt[i] <= 1'b0;
    endtask

    // pulse must come between lo and hi cycles and last one cycle only
    task automatic waitPulse(input int lo, input int hi);
        int n;
        n = 0;
        while (watchdogResetPulse !== 1'b1 && n <= hi) begin
            @(negedge clkSys);
            n++;
        end
        chkVal({31'h0, (n >= lo && n <= hi)}, 32'h1);
        @(negedge clkSys);
        chkVal({31'h0, watchdogResetPulse}, 32'h0);
    endtask

    task automatic waitNone(input int n);
        int seen;
        seen = 0;
        repeat (n) begin
            @(negedge clkSys);
            if (watchdogResetPulse !== 1'b0) seen++;
        end
        chkVal(32'(seen), 32'h0);
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (5) @(posedge clkSys);
        arstN <= 1'b1;
        repeat (4) @(posedge clkSys);
        chkReg(wdrc_pkg::ADDR_RESET_CAUSE, 8'h01);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h00);
        chkVal({31'h0, watchdogActive}, 32'h0);
        chkReg(4'h8, 8'h00);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h08, 4'h0);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h00);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'hE8);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h08);
        chkVal({31'h0, watchdogActive}, 32'h1);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h07);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h08);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h18);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h18);
        repeat (4) @(posedge clkSys);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h08);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h18);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h00);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h00);
        chkVal({31'h0, watchdogActive}, 32'h0);
        waitNone(6 * DIV);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h08);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h18);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h09);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h09);
        waitPulse(7 * DIV - 2, 8 * DIV + 3);
        chkReg(wdrc_pkg::ADDR_RESET_CAUSE, 8'h09);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h00);
        busWr(wdrc_pkg::ADDR_RESET_CAUSE, 8'h00);
        chkReg(wdrc_pkg::ADDR_RESET_CAUSE, 8'h00);
        busWr(wdrc_pkg::ADDR_RESET_CAUSE, 8'hFF);
        chkReg(wdrc_pkg::ADDR_RESET_CAUSE, 8'h00);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h08);
        repeat (6) begin
            waitNone(2 * DIV);
            fire(0);
        end
        waitPulse(3 * DIV, 4 * DIV + 3);
        chkReg(wdrc_pkg::ADDR_RESET_CAUSE, 8'h08);
        for (int i = 1; i <= 3; i++) begin
            busWr(wdrc_pkg::ADDR_RESET_CAUSE, 8'h00);
            busWr(wdrc_pkg::ADDR_CONTROL, 8'h08);
            fire(i);
            chkReg(wdrc_pkg::ADDR_RESET_CAUSE, 8'h01 << flagPos[i]);
            chkReg(wdrc_pkg::ADDR_CONTROL, 8'h00);
        end
        // power-on again with the fuse programmed
        @(posedge clkSys);
        arstN <= 1'b0;
        alwaysOnFuse <= 1'b1;
        repeat (5) @(posedge clkSys);
        arstN <= 1'b1;
        repeat (4) @(posedge clkSys);
        chkReg(wdrc_pkg::ADDR_RESET_CAUSE, 8'h01);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h08);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h18);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h00);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h08);
        chkVal({31'h0, watchdogActive}, 32'h1);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h02);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h08);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h18);
        busWr(wdrc_pkg::ADDR_CONTROL, 8'h02);
        chkReg(wdrc_pkg::ADDR_CONTROL, 8'h0A);
        waitPulse(15 * DIV - 2, 16 * DIV + 3);
        stopTest();
    end

    // whole run needs roughly 6000 cycles
    initial begin
        repeat (40000) @(posedge clkSys);
        nErrors++;
        stopTest();
    end
endmodule // wdrc_top_tb_top
